// File: core/sleep_pkg.sv
package sleep_pkg;

   // power saving modes
   localparam logic [7:0] MODE_ACTIVE   = 8'h00;
   localparam logic [7:0] MODE_SLEEP1   = 8'h01;
   localparam logic [7:0] MODE_SLEEP2   = 8'h02;
   localparam logic [7:0] MODE_SNIFF1   = 8'h03;
   localparam logic [7:0] MODE_SNIFF2   = 8'h04;
   localparam logic [7:0] MODE_SNIFF3   = 8'h05;

   // settings after reset and least legal values
   localparam logic [7:0]  RST_MODE     = 8'h00;
   localparam logic [15:0] RST_SLEEP    = 16'h003C;
   localparam logic [15:0] RST_AWAKE    = 16'h000A;
   localparam logic [7:0]  RST_HOPS     = 8'h0A;
   localparam logic        RST_INTAKE   = 1'b0;
   localparam logic [15:0] MIN_SLEEP    = 16'h0002;
   localparam logic [7:0]  MIN_HOPS     = 8'h01;

   // one second tick from the 50 MHz clock
   localparam int CLK_HZ     = 50000000;
   localparam int TICK_SECS  = 1;
   localparam int TICK_CYC   = CLK_HZ * TICK_SECS;

   // settings written by the host
   typedef struct packed {
      logic [7:0]  mode;
      logic [15:0] sleep_secs;
      logic [15:0] awake_secs;
      logic [7:0]  hops;
      logic        intake;
   } settings_t;

   // activity and link indications
   typedef struct packed {
      logic serial_act;
      logic rf_act;
      logic hop_strobe;
      logic synced;
      logic pending;
   } activity_t;

endpackage

// File: core/sec_tick.sv
// one-cycle pulse once per period; restarted by clear
module sec_tick #(
   parameter int PERIOD = 50000000
) (
   // clock and reset
   input  wire logic clk,
   input  wire logic rst,
   // control
   input  wire logic clear,
   output logic      tick
);

   logic [31:0] count;

   // free running divider
   always_ff @(posedge clk) begin
      if (rst || clear) begin
         count <= 32'h0000_0000;
         tick  <= 1'b0;
      end else if (count == 32'(PERIOD - 1)) begin
         count <= 32'h0000_0000;
         tick  <= 1'b1;
      end else begin
         count <= count + 32'h0000_0001;
         tick  <= 1'b0;
      end
   end

endmodule

// File: core/down_timer.sv
// loadable down counter, done while zero
module down_timer #(
   parameter int W = 16
) (
   // clock and reset
   input  wire logic         clk,
   input  wire logic         rst,
   // control
   input  wire logic         load,
   input  wire logic [W-1:0] value,
   input  wire logic         step,
   output logic              done
);

   logic [W-1:0] count;

   assign done = (count == '0);

   // reload wins over step
   always_ff @(posedge clk) begin
      if (rst)
         count <= '0;
      else if (load)
         count <= value;
      else if (step && !done)
         count <= count - W'(1);
   end

endmodule

// File: core/remote_sleep_sniff_control.sv
// How it works
// - mode 0 keeps the unit awake all the time with no timed sleep.
// - mode 1 sleeps for the sleep time after the wake time idles on both.
// - serial data in any sleep or sniff mode wakes the unit fully at once.
// - asleep, expiry outside sniff modes or a falling edge on external_wake_n wakes the unit.
// - awake holds the wake time, then sleeps only with wake high, no data.
// - mode 2 counts only serial traffic as activity.
// - mode 3 sniffs for an upstream unit for hops times the hop interval.
// - sniff finding a master holds the wake time and until data is sent.
// - sniff with no master found in the hop count returns to sleep.
// - mode 4 sniffs but counts only serial traffic as activity.
// - mode 5 sniffs like mode 3 and discards buffered data on no master.
// - sleep time is seconds 2 to 65535, default 60, used if mode nonzero.
// - wake time is seconds 0 to 65535, default 10, used if mode nonzero.
// - in sniff modes sleep expiry starts a sniff, serial data a wake.
// - intake 0 drops unsynced data, 1 buffers it until sync returns.
// - sniff hop count is 1 to 255, default 10, used at sleep expiry.
module remote_sleep_sniff_control #(
   // cycles in one second tick
   parameter int TICK_PERIOD = sleep_pkg::TICK_CYC
) (
   // clock and reset
   input  wire logic                clk,
   input  wire logic                rst,
   // settings port
   input  wire logic                cfg_write,
   input  wire sleep_pkg::settings_t cfg_in,
   output sleep_pkg::settings_t     cfg_out,
   // activity and link
   input  wire sleep_pkg::activity_t act,
   input  wire logic                external_wake_n,
   input  wire logic                is_remote,
   // power and data path control
   output logic                     awake,
   output logic                     sniffing,
   output logic                     discard_buffer,
   output logic                     accept_rx,
   output logic                     buffer_rx
);

   typedef enum logic [1:0] {ST_AWAKE, ST_SLEEP, ST_SNIFF} state_t;

   ////////////////////////////////////////////////////////////////////////
   // settings registers

   sleep_pkg::settings_t cfg;
   sleep_pkg::settings_t next_cfg;

   // clamp values below their least legal value
   always_comb begin
      next_cfg = cfg_in;
      if (cfg_in.sleep_secs < sleep_pkg::MIN_SLEEP)
         next_cfg.sleep_secs = sleep_pkg::MIN_SLEEP;
      if (cfg_in.hops < sleep_pkg::MIN_HOPS)
         next_cfg.hops = sleep_pkg::MIN_HOPS;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         cfg.mode       <= sleep_pkg::RST_MODE;
         cfg.sleep_secs <= sleep_pkg::RST_SLEEP;
         cfg.awake_secs <= sleep_pkg::RST_AWAKE;
         cfg.hops       <= sleep_pkg::RST_HOPS;
         cfg.intake     <= sleep_pkg::RST_INTAKE;
      end else if (cfg_write) begin
         cfg <= next_cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // mode decode

   wire power_save = is_remote && (cfg.mode != sleep_pkg::MODE_ACTIVE);
   wire mode_sniff = (cfg.mode == sleep_pkg::MODE_SNIFF1) ||
                     (cfg.mode == sleep_pkg::MODE_SNIFF2) ||
                     (cfg.mode == sleep_pkg::MODE_SNIFF3);
   wire mode_known = (cfg.mode <= sleep_pkg::MODE_SNIFF3);
   wire serial_only = (cfg.mode == sleep_pkg::MODE_SLEEP2) ||
                      (cfg.mode == sleep_pkg::MODE_SNIFF2);
   // rf traffic counts unless the mode is serial only
   wire activity = act.serial_act ||
                   (act.rf_act && !serial_only);

   ////////////////////////////////////////////////////////////////////////
   // wake pin falling edge

   logic wake_prev;
   always_ff @(posedge clk) begin
      if (rst)
         wake_prev <= 1'b1;
      else
         wake_prev <= external_wake_n;
   end
   wire wake_fall = wake_prev && !external_wake_n;

   ////////////////////////////////////////////////////////////////////////
   // state machine

   state_t state;
   state_t next_state;
   logic   sec_tick_pulse;
   logic   hold_done;
   logic   sleep_done;
   logic   hops_done;
   logic   master_seen;
   wire    re_arm = (next_state != state) ||
                    (state == ST_AWAKE && activity);

   always_comb begin
      next_state = state;
      unique case (state)
         ST_AWAKE: begin
            // sleep once held long enough, idle, pin high, queue empty
            if (power_save && mode_known && hold_done && !activity &&
                external_wake_n && !act.pending &&
                !(mode_sniff && !master_seen && act.pending))
               next_state = ST_SLEEP;
         end
         ST_SLEEP: begin
            if (!power_save || act.serial_act)
               next_state = ST_AWAKE;
            else if (wake_fall)
               next_state = ST_AWAKE;
            else if (sleep_done)
               next_state = mode_sniff ? ST_SNIFF :
                                         ST_AWAKE;
         end
         ST_SNIFF: begin
            if (!power_save || act.serial_act || wake_fall)
               next_state = ST_AWAKE;
            else if (act.synced)
               next_state = ST_AWAKE;
            else if (hops_done)
               next_state = ST_SLEEP;
         end
         default: next_state = ST_AWAKE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (rst)
         state <= ST_AWAKE;
      else
         state <= next_state;
   end

   // remember whether the wake came from a found master
   always_ff @(posedge clk) begin
      if (rst)
         master_seen <= 1'b0;
      else if (state == ST_SNIFF && act.synced)
         master_seen <= 1'b1;
      else if (state == ST_SLEEP)
         master_seen <= 1'b0;
   end

   ////////////////////////////////////////////////////////////////////////
   // timers

   // second tick restarts with every re-arm
   sec_tick #(.PERIOD(TICK_PERIOD)) u_tick (
      .clk   (clk),
      .rst   (rst),
      .clear (re_arm),
      .tick  (sec_tick_pulse)
   );

   // wake hold, reloaded on activity and state change
   down_timer #(.W(16)) u_hold (
      .clk   (clk),
      .rst   (rst),
      .load  (re_arm),
      .value (cfg.awake_secs),
      .step  (sec_tick_pulse),
      .done  (hold_done)
   );

   down_timer #(.W(16)) u_sleep (
      .clk   (clk),
      .rst   (rst),
      .load  (re_arm),
      .value (cfg.sleep_secs),
      .step  (sec_tick_pulse),
      .done  (sleep_done)
   );

   // sniff window counted in hop strobes
   down_timer #(.W(8)) u_hops (
      .clk   (clk),
      .rst   (rst),
      .load  (re_arm),
      .value (cfg.hops),
      .step  (act.hop_strobe),
      .done  (hops_done)
   );

   ////////////////////////////////////////////////////////////////////////
   // registered outputs

   wire next_discard = (state == ST_SNIFF) && hops_done && !act.synced &&
                       !act.serial_act && !wake_fall && power_save &&
                       (cfg.mode == sleep_pkg::MODE_SNIFF3);

   always_ff @(posedge clk) begin
      if (rst) begin
         awake          <= 1'b1;
         sniffing       <= 1'b0;
         discard_buffer <= 1'b0;
         accept_rx      <= 1'b1;
         buffer_rx      <= 1'b0;
         cfg_out        <= '0;
      end else begin
         awake          <= (next_state == ST_AWAKE);
         sniffing       <= (next_state == ST_SNIFF);
         discard_buffer <= next_discard;
         accept_rx      <= act.synced || cfg.intake;
         buffer_rx      <= !act.synced && cfg.intake;
         cfg_out        <= cfg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks

   // named steps of the power state
   sequence s_sleeping;
      state == ST_SLEEP;
   endsequence

   sequence s_sniffing;
      state == ST_SNIFF;
   endsequence

   a_mode_zero_awake: assert property (@(posedge clk) disable iff (rst)
      (cfg.mode == sleep_pkg::MODE_ACTIVE) |=> state == ST_AWAKE)
      else $error("mode zero left awake state");

   a_local_awake: assert property (@(posedge clk) disable iff (rst)
      !is_remote |=> state == ST_AWAKE)
      else $error("local unit left awake state");

   a_serial_wakes: assert property (@(posedge clk) disable iff (rst)
      (state != ST_AWAKE && act.serial_act) |=> state == ST_AWAKE)
      else $error("serial data did not wake unit");

   a_pin_wakes: assert property (@(posedge clk) disable iff (rst)
      (s_sleeping and wake_fall) |=> state == ST_AWAKE)
      else $error("wake pin edge ignored");

   a_expiry_wakes: assert property (@(posedge clk) disable iff (rst)
      (s_sleeping and sleep_done and !mode_sniff) |=> state == ST_AWAKE)
      else $error("sleep expiry did not wake unit");

   a_hold_wake: assert property (@(posedge clk) disable iff (rst)
      (state == ST_AWAKE && !hold_done) |=> state != ST_SLEEP)
      else $error("slept before wake time");

   a_traffic_awake: assert property (@(posedge clk)
      disable iff (rst) (state == ST_AWAKE && activity) |=> state == ST_AWAKE)
      else $error("slept with traffic present");

   a_pending_awake: assert property (@(posedge clk) disable iff (rst)
      (state == ST_AWAKE && act.pending) |=> state == ST_AWAKE)
      else $error("slept with data pending");

   // sniff outcome checks
   a_sniff_found: assert property (@(posedge clk) disable iff (rst)
      (s_sniffing and act.synced) |=> state == ST_AWAKE)
      else $error("found master did not wake unit");

   a_sniff_expiry: assert property (@(posedge clk) disable iff (rst)
      (s_sleeping and sleep_done and mode_sniff and power_save
       and !act.serial_act and !wake_fall)
      |=> state == ST_SNIFF)
      else $error("sleep expiry did not sniff");

   a_sniff_fail: assert property (@(posedge clk) disable iff (rst)
      (state == ST_SNIFF && hops_done && !act.synced && power_save &&
       !act.serial_act && !wake_fall) |=> state == ST_SLEEP)
      else $error("failed sniff did not sleep");

   a_discard_fail: assert property (@(posedge clk) disable iff (rst)
      next_discard |=> (discard_buffer && state == ST_SLEEP))
      else $error("failed sniff did not discard");

   a_discard_once: assert property (@(posedge clk) disable iff (rst)
      discard_buffer |=> !discard_buffer)
      else $error("discard held past one cycle");

   // data path and output checks
   a_intake_drop: assert property (@(posedge clk) disable iff (rst)
      (!act.synced && !cfg.intake) |=> !accept_rx)
      else $error("unsynced data accepted");

   a_intake_keep: assert property (@(posedge clk) disable iff (rst)
      (!act.synced && cfg.intake) |=> (accept_rx && buffer_rx))
      else $error("unsynced data not buffered");

   a_state_shown: assert property (@(posedge clk) disable iff (rst)
      (awake == (state == ST_AWAKE)) && (sniffing == (state == ST_SNIFF)))
      else $error("outputs differ from state");

endmodule

// File: verif/far_side.sv
////////////////////////////////////////////////////////////////////////////
// serial host and radio link seen from the controller
module far_side (
   // clock
   input  wire logic            clk,
   // bench controls
   input  wire logic            serial_on,
   input  wire logic            rf_on,
   input  wire logic            sync_on,
   input  wire logic            pend_on,
   input  wire logic            wake_on,
   // toward the controller
   output sleep_pkg::activity_t act,
   output logic                 external_wake_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [3:0] hop_cnt = 4'h0;
   // hop interval of sixteen cycles, strobe on the last one
   always_ff @(posedge clk) begin
      hop_cnt <= hop_cnt + 4'h1;
   end
   // traffic, link state and pending data as levels
   assign act = '{serial_act: serial_on, rf_act: rf_on,
                  hop_strobe: (hop_cnt == 4'hF), synced: sync_on,
                  pending: pend_on};
   assign external_wake_n = ~wake_on; // pin pulled high when idle
endmodule

// File: verif/tb.sv
////////////////////////////////////////////////////////////////////////////
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {string name; logic [4:0] exp; logic [4:0] mask;} note_t;
   logic clk, rst, cfg_write, is_remote, ext_wake_n;
   logic serial_on, rf_on, sync_on, pend_on, wake_on;
   logic awake, sniffing, discard_buffer, accept_rx, buffer_rx;
   sleep_pkg::settings_t cfg_in, cfg_out;
   sleep_pkg::activity_t act;
   logic [31:0] lfsr = 32'h73D1F0BE;
   int err_total = 0, checked = 0, cycles = 0;
   note_t notes[$];
   wire [4:0] outs = {awake, sniffing, discard_buffer, accept_rx, buffer_rx};

   far_side u_far (.clk(clk), .serial_on(serial_on), .rf_on(rf_on),
      .sync_on(sync_on), .pend_on(pend_on), .wake_on(wake_on), .act(act),
      .external_wake_n(ext_wake_n));
   remote_sleep_sniff_control #(.TICK_PERIOD(40)) u_dut (.clk(clk), .rst(rst),
      .cfg_write(cfg_write), .cfg_in(cfg_in), .cfg_out(cfg_out), .act(act),
      .external_wake_n(ext_wake_n), .is_remote(is_remote), .awake(awake),
      .sniffing(sniffing), .discard_buffer(discard_buffer),
      .accept_rx(accept_rx), .buffer_rx(buffer_rx));

   ////////////////////////////////////////////////////////////////////////
   function automatic logic [31:0] lfsr_next(input logic [31:0] v);
      return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
   endfunction
   task automatic check(input string nm, input logic [48:0] seen,
                        input logic [48:0] exp);
      checked++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic note(input string nm, input logic [4:0] e, input logic [4:0] m);
      notes.push_back('{nm, e, m});
   endtask
   // poll the masked outputs under a bound, then hand the note over
   task automatic settle(input string nm, input logic [4:0] e,
                         input logic [4:0] m);
      for (int i = 0; i < 120 && (outs & m) !== e; i++) cyc(1);
      note(nm, e, m);
   endtask
   task automatic setup(input logic [7:0] m, input logic [15:0] sl,
                        input logic [15:0] wk, input logic [7:0] h, input logic in);
      cfg_in = '{m, sl, wk, h, in};
      cfg_write = 1'b1;
      cyc(1);
      cfg_write = 1'b0;
      cyc(2);
   endtask
   task automatic tally_and_finish();
      wait (notes.size() == 0);
      $display("checks %0d mismatches %0d", checked, err_total);
      if (err_total == 0 && checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   // clock, timeout and the output watcher
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   always @(posedge clk) begin
      cycles++;
      if (cycles == 6000) begin
         err_total++;
         tally_and_finish();
      end
   end
   initial begin
      note_t n;
      forever begin
         wait (notes.size() != 0);
         n = notes.pop_front();
         check(n.name, 49'(outs & n.mask), 49'(n.exp));
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // main sequence
   initial begin
      {rst, is_remote, sync_on} = 3'b111;
      {cfg_write, serial_on, rf_on, pend_on, wake_on} = 5'h00;
      cfg_in = '0;
      cyc(12);
      note("reset outputs", 5'h12, 5'h1F);
      rst = 1'b0;
      cyc(2);
      check("defaults", cfg_out, {8'h00, 16'h003C, 16'h000A, 8'h0A, 1'b0});
      setup(8'h00, 16'h0000, 16'h0000, 8'h00, 1'b0);
      check("clamps", cfg_out, {8'h00, 16'h0002, 16'h0000, 8'h01, 1'b0});
      cyc(40);
      note("mode0 awake", 5'h10, 5'h10);
      is_remote = 1'b0;
      setup(8'h01, 16'h0002, 16'h0000, 8'h01, 1'b0);
      cyc(40);
      note("local awake", 5'h10, 5'h10);
      is_remote = 1'b1;
      $display("test settings done");
      for (int m = 1; m <= 5; m++) begin
         setup(8'(m), 16'h0002, 16'h0001, 8'h01, 1'b0);
         sync_on = 1'b0;
         settle("idle sleep", 5'h00, 5'h10);
         note("no sniff yet", 5'h00, 5'h0C);
         serial_on = 1'b1;
         cyc(3);
         note("serial wake", 5'h10, 5'h18);
         serial_on = 1'b0;
         cyc(30);
         note("wake time", 5'h10, 5'h10);
         settle("resleep", 5'h00, 5'h10);
         wake_on = 1'b1;
         cyc(3);
         note("pin wake", 5'h10, 5'h18);
         cyc(50);
         note("pin holds", 5'h10, 5'h10);
         {wake_on, pend_on} = 2'b01;
         cyc(30);
         note("pending holds", 5'h10, 5'h10);
         pend_on = 1'b0;
         settle("drained sleep", 5'h00, 5'h10);
         for (int i = 0; i < 20; i++) begin
            lfsr = lfsr_next(lfsr);
            rf_on = lfsr[0];
            cyc(1);
         end
         rf_on = 1'b0;
         note("rf no wake", 5'h00, 5'h10);
         if (m >= 3) begin
            settle("sniff start", 5'h08, 5'h18);
            settle("sniff fail", 5'h00, 5'h18);
            note("discard", {2'b00, m == 5, 2'b00}, 5'h04);
            sync_on = 1'b1;
            settle("sniff found", 5'h10, 5'h18);
         end else begin
            settle("expiry wake", 5'h10, 5'h18);
         end
         rf_on = 1'b1;
         cyc(60);
         note("rf holds", {m != 2 && m != 4, 4'h0}, 5'h10);
         rf_on = 1'b0;
         settle("idle again", 5'h00, 5'h10);
         $display("test mode %0d done", m);
      end
      for (int i = 0; i < 24; i++) begin
         lfsr = lfsr_next(lfsr);
         rf_on = lfsr[2];
         setup(8'h00, 16'h003C, 16'h000A, 8'h0A, lfsr[0]);
         sync_on = lfsr[1];
         cyc(2);
         note("intake", {3'b000, lfsr[1] | lfsr[0], ~lfsr[1] & lfsr[0]}, 5'h03);
      end
      $display("test intake done");
      tally_and_finish();
   end
endmodule
